// [rtl/obc_config_decode.sv]
module obc_config_decode
	import obc_pkg::*;
#(
	parameter bit LARGE_MEM  = 1'b1,
	parameter int SYNC_DEPTH = OBC_SYNC_DEPTH
) (
	// Clock and reset
	input  wire logic     clk_sys_i,
	input  wire logic     rst_i,
	// Programming mode pin
	input  wire logic     prog_mode_i,
	// Tool request and answer
	input  wire logic     req_valid_i,
	input  wire obc_req_t req_i,
	output logic          ack_o,
	output logic          refused_o,
	output logic [7:0]    rdata_o,
	// Non-volatile option storage
	input  wire logic [7:0] nv_byte0_i,
	input  wire logic [7:0] nv_byte1_i,
	output logic          nv_wr_o,
	output obc_nvw_t      nv_w_o,
	output logic          mem_wipe_o,
	input  wire logic     mem_wipe_done_i,
	// Decoded settings
	output obc_cfg_t      cfg_o,
	output logic          flash_read_ok_o,
	output logic          flash_write_ok_o,
	// Watchdog
	input  wire logic     dog_sw_enable_i,
	input  wire logic     halt_entry_i,
	output logic          dog_enable_o,
	output logic          halt_reset_o
);

	if (SYNC_DEPTH != 3) begin : g_chk
		$error("SYNC_DEPTH must be 3");
	end

	// ==========================================================
	// Programming mode synchroniser
	// ==========================================================
	logic [2:0] sync_q, sync_d;
	logic       mode_q, mode_d;

	always_comb begin
		sync_d = {sync_q[1:0], prog_mode_i};
		mode_d = mode_q;
		if (sync_q[1] == sync_q[2]) begin
			mode_d = sync_q[2];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync_q <= 3'h0;
			mode_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			mode_q <= mode_d;
		end
	end

	// ==========================================================
	// Option byte access sequencer
	// ==========================================================
	obc_state_t st_q, st_d;
	logic       ack_q, ack_d, ref_q, ref_d, nv_wr_q, nv_wr_d;
	logic       wipe_q, wipe_d;
	logic [7:0] rdata_q, rdata_d;
	obc_nvw_t   nv_w_q, nv_w_d;
	logic       wr_lock, rd_lock;

	// Lock read from live storage so a fresh lock bites at once
	assign wr_lock = nv_byte0_i[OBC_B0_WR_LOCK];
	assign rd_lock = nv_byte0_i[OBC_B0_READ_LOCK];

	always_comb begin
		st_d    = st_q;
		ack_d   = 1'b0;
		ref_d   = 1'b0;
		nv_wr_d = 1'b0;
		nv_w_d  = nv_w_q;
		wipe_d  = wipe_q;
		rdata_d = rdata_q;
		unique case (st_q)
			OBC_ST_IDLE: begin
				if (req_valid_i && !mode_q) begin
					ack_d = 1'b1; // [R13]
					ref_d = 1'b1; // [R13]
				end else if (req_valid_i) begin
					ack_d = 1'b1;
					unique case (req_i.cmd)
						OBC_CMD_READ: begin
							rdata_d = req_i.sel ? nv_byte1_i : nv_byte0_i;
						end
						OBC_CMD_WRITE: begin
							if (!req_i.sel && wr_lock) begin
								ref_d = 1'b1; // [R5]
							end else begin
								nv_wr_d = 1'b1;
								nv_w_d  = '{sel: req_i.sel, data: req_i.wdata};
							end
						end
						OBC_CMD_ERASE: begin
							ack_d = 1'b0;
							if (wr_lock) begin
								ack_d = 1'b1; // [R5]
								ref_d = 1'b1;
							end else if (rd_lock) begin
								wipe_d = 1'b1; // [R4]
								st_d   = OBC_ST_WIPE;
							end else begin
								st_d = OBC_ST_ERASE0;
							end
						end
						default: begin
							ref_d = 1'b1;
						end
					endcase
				end
			end
			OBC_ST_WIPE: begin
				if (mem_wipe_done_i) begin
					wipe_d = 1'b0; // [R4]
					st_d   = OBC_ST_ERASE0;
				end
			end
			OBC_ST_ERASE0: begin
				nv_wr_d = 1'b1;
				nv_w_d  = '{sel: 1'b0, data: OBC_ERASED};
				st_d    = OBC_ST_ERASE1;
			end
			OBC_ST_ERASE1: begin
				nv_wr_d = 1'b1;
				nv_w_d  = '{sel: 1'b1, data: OBC_ERASED};
				ack_d   = 1'b1;
				st_d    = OBC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			st_q    <= OBC_ST_IDLE;
			ack_q   <= 1'b0;
			ref_q   <= 1'b0;
			nv_wr_q <= 1'b0;
			nv_w_q  <= '{sel: 1'b0, data: OBC_ERASED};
			wipe_q  <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			st_q    <= st_d;
			ack_q   <= ack_d;
			ref_q   <= ref_d;
			nv_wr_q <= nv_wr_d;
			nv_w_q  <= nv_w_d;
			wipe_q  <= wipe_d;
			rdata_q <= rdata_d;
		end
	end

	assign ack_o      = ack_q;
	assign refused_o  = ref_q;
	assign rdata_o    = rdata_q;
	assign nv_wr_o    = nv_wr_q;
	assign nv_w_o     = nv_w_q;
	assign mem_wipe_o = wipe_q;

	// ==========================================================
	// Settings capture and decode
	// ==========================================================
	obc_cfg_t cfg_q, cfg_d;
	logic     frd_q, frd_d, fwr_q, fwr_d, dog_q, dog_d, hrst_q, hrst_d;

	always_comb begin
		cfg_d = cfg_q;
		if (rst_i) begin
			unique case (nv_byte0_i[OBC_B0_SIZE_LSB +: 2])
				2'h0:    cfg_d.sector = OBC_SEC_HALF; // [R1]
				2'h1:    cfg_d.sector = OBC_SEC_ONE; // [R1]
				default: cfg_d.sector = LARGE_MEM ? OBC_SEC_ONEHALF
				                                  : OBC_SEC_ONE; // [R1]
			endcase
			cfg_d.read_lock  = nv_byte0_i[OBC_B0_READ_LOCK];
			cfg_d.write_lock = nv_byte0_i[OBC_B0_WR_LOCK];
			cfg_d.mult8      = nv_byte1_i[OBC_B1_MULT]; // [R6]
			cfg_d.pll_on     = !nv_byte1_i[OBC_B1_BYPASS]; // [R7]
			cfg_d.rc_on      = !nv_byte1_i[OBC_B1_RC_OFF]; // [R8]
			cfg_d.bo_sel     = nv_byte1_i[OBC_B1_BO_LSB +: 2]; // [R10]
			cfg_d.dog_hw     = !nv_byte1_i[OBC_B1_DOG_SW]; // [R11]
			cfg_d.dog_halt   = nv_byte1_i[OBC_B1_DOG_HALT];
		end
		frd_d  = !cfg_d.read_lock; // [R3]
		fwr_d  = !cfg_d.read_lock && !cfg_d.write_lock; // [R3] [R5]
		// Cleared in reset; hardware mode rises one edge after release
		dog_d  = !rst_i && (cfg_d.dog_hw || dog_q || dog_sw_enable_i); // [R11]
		hrst_d = !rst_i && halt_entry_i && cfg_q.dog_halt && dog_q; // [R12]
	end

	always_ff @(posedge clk_sys_i) begin
		cfg_q  <= cfg_d; // [R14]
		frd_q  <= frd_d;
		fwr_q  <= fwr_d;
		dog_q  <= dog_d;
		hrst_q <= hrst_d;
	end

	assign cfg_o            = cfg_q;
	assign flash_read_ok_o  = frd_q;
	assign flash_write_ok_o = fwr_q;
	assign dog_enable_o     = dog_q;
	assign halt_reset_o     = hrst_q;

	// ==========================================================
	// Checks
	// ==========================================================
	outside_refused_a: assert property ( // [R13]
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && st_q == OBC_ST_IDLE && !mode_q
		|=> ack_o && refused_o && !nv_wr_o)
		else $error("request outside programming mode not refused");

	read_answer_a: assert property ( // [R13]
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && st_q == OBC_ST_IDLE && mode_q
		&& req_i.cmd == OBC_CMD_READ
		|=> ack_o && !refused_o
		&& rdata_o == ($past(req_i.sel) ? $past(nv_byte1_i)
		                                : $past(nv_byte0_i)))
		else $error("read answer wrong");

	lock_write_a: assert property ( // [R5]
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && st_q == OBC_ST_IDLE && mode_q && wr_lock
		&& (req_i.cmd == OBC_CMD_ERASE
		|| (req_i.cmd == OBC_CMD_WRITE && !req_i.sel))
		|=> refused_o && !nv_wr_o && !mem_wipe_o)
		else $error("locked byte altered");

	wipe_first_a: assert property ( // [R4]
		@(posedge clk_sys_i) disable iff (rst_i)
		st_q == OBC_ST_WIPE && mem_wipe_done_i
		|-> !nv_wr_o ##1 !nv_wr_o ##1 (nv_wr_o && !nv_w_o.sel)
		##1 (nv_wr_o && nv_w_o.sel && ack_o))
		else $error("option erase order wrong");

	cfg_hold_a: assert property ( // [R14]
		@(posedge clk_sys_i) disable iff (rst_i)
		!rst_i |=> $stable(cfg_o))
		else $error("settings changed outside reset");

	clk_decode_a: assert property ( // [R6] [R7] [R8]
		@(posedge clk_sys_i)
		$fell(rst_i) |-> cfg_o.mult8 == $past(nv_byte1_i[OBC_B1_MULT])
		&& cfg_o.pll_on == !$past(nv_byte1_i[OBC_B1_BYPASS])
		&& cfg_o.rc_on == !$past(nv_byte1_i[OBC_B1_RC_OFF]))
		else $error("clock settings decoded wrong");

	bo_sector_a: assert property ( // [R1] [R10]
		@(posedge clk_sys_i)
		$fell(rst_i) |-> cfg_o.bo_sel == $past(nv_byte1_i[3:2])
		&& (cfg_o.sector == OBC_SEC_HALF) == ($past(nv_byte0_i[3:2]) == 2'h0))
		else $error("size or threshold decoded wrong");

	flash_guard_a: assert property ( // [R3]
		@(posedge clk_sys_i) disable iff (rst_i)
		flash_write_ok_o == (!cfg_o.read_lock && !cfg_o.write_lock)
		&& flash_read_ok_o == !cfg_o.read_lock)
		else $error("flash protection wrong");

	hw_dog_a: assert property ( // [R11]
		@(posedge clk_sys_i) disable iff (rst_i)
		(cfg_o.dog_hw && !$past(rst_i) |-> dog_enable_o)
		and (!cfg_o.dog_hw && !dog_enable_o && !dog_sw_enable_i
		|=> !dog_enable_o))
		else $error("watchdog enable wrong");

	halt_reset_a: assert property ( // [R12]
		@(posedge clk_sys_i) disable iff (rst_i)
		halt_entry_i && cfg_o.dog_halt && dog_enable_o
		|=> halt_reset_o)
		else $error("halt reset missing");

	halt_quiet_a: assert property ( // [R12]
		@(posedge clk_sys_i) disable iff (rst_i)
		!(halt_entry_i && cfg_o.dog_halt) |=> !halt_reset_o)
		else $error("halt reset spurious");

	write_land_a: assert property ( // [R13]
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && st_q == OBC_ST_IDLE && mode_q
		&& req_i.cmd == OBC_CMD_WRITE && (req_i.sel || !wr_lock)
		|=> ack_o && !refused_o && nv_wr_o
		&& nv_w_o.sel == $past(req_i.sel)
		&& nv_w_o.data == $past(req_i.wdata))
		else $error("accepted write not passed to storage");

	wipe_hold_a: assert property ( // [R4]
		@(posedge clk_sys_i) disable iff (rst_i)
		mem_wipe_o && !mem_wipe_done_i |-> !nv_wr_o ##1 mem_wipe_o)
		else $error("wipe dropped early");

	plain_erase_a: assert property ( // [R4]
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && st_q == OBC_ST_IDLE && mode_q
		&& req_i.cmd == OBC_CMD_ERASE && !wr_lock && !rd_lock
		|=> !mem_wipe_o && !ack_o ##1 (nv_wr_o && !nv_w_o.sel)
		##1 (nv_wr_o && nv_w_o.sel && ack_o))
		else $error("plain option erase wrong");

endmodule // obc_config_decode

// [rtl/obc_pkg.sv]
// Function
// R1: first_block_size 00 gives 0.5k, 01 gives 1k, upper bit set gives 1.5k (code gives 1k there when LARGE_MEM is 0).
// R2: Programmer writes ones into reserved bits 7:4 of byte zero, bit 5 of one.
// R3: readout_lock set blocks program memory extraction and flash writes.
// R4: Option erase under readout_lock wipes the whole memory first.
// R5: program_write_lock set forever refuses memory and lock bit changes.
// R6: multiplier_factor 0 selects times four, 1 selects times eight.
// R7: multiplier_bypass 0 enables the PLL, 1 bypasses it.
// R8: internal_rc_disable 0 runs the RC oscillator, 1 uses external clock.
// R9: Programmer picks only clock combinations valid for the supply range.
// R10: brownout_threshold_sel 11 off, 10 high, 01 medium, 00 low threshold.
// R11: dog_hw_sw_sel 0 keeps watchdog always on, 1 waits for software.
// R12: dog_reset_on_stop 1 with active watchdog resets on halt entry.
// R13: Option bytes are reachable by the tool only in programming mode.
// R14: Settings captured during reset and held stable until next reset.
package obc_pkg;

	// ==========================================================
	// Option byte layout and values
	// ==========================================================
	localparam logic [7:0] OBC_BYTE0_RST = 8'hFC;
	localparam logic [7:0] OBC_BYTE1_RST = 8'hEF;
	localparam logic [7:0] OBC_ERASED    = 8'hFF;
	localparam int         OBC_B0_SIZE_LSB  = 2;
	localparam int         OBC_B0_READ_LOCK = 1;
	localparam int         OBC_B0_WR_LOCK   = 0;
	localparam int         OBC_B1_MULT      = 7;
	localparam int         OBC_B1_BYPASS    = 6;
	localparam int         OBC_B1_RC_OFF    = 4;
	localparam int         OBC_B1_BO_LSB    = 2;
	localparam int         OBC_B1_DOG_SW    = 1;
	localparam int         OBC_B1_DOG_HALT  = 0;
	localparam int         OBC_SYNC_DEPTH   = 3;

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [1:0] {
		OBC_SEC_HALF    = 2'h0,
		OBC_SEC_ONE     = 2'h1,
		OBC_SEC_ONEHALF = 2'h2
	} obc_sector_t;

	typedef enum logic [1:0] {
		OBC_CMD_READ  = 2'h0,
		OBC_CMD_WRITE = 2'h1,
		OBC_CMD_ERASE = 2'h2
	} obc_cmd_t;

	typedef enum logic [1:0] {
		OBC_ST_IDLE   = 2'h0,
		OBC_ST_WIPE   = 2'h1,
		OBC_ST_ERASE0 = 2'h2,
		OBC_ST_ERASE1 = 2'h3
	} obc_state_t;

	typedef struct packed {
		obc_cmd_t   cmd;
		logic       sel;
		logic [7:0] wdata;
	} obc_req_t;

	typedef struct packed {
		logic       sel;
		logic [7:0] data;
	} obc_nvw_t;

	typedef struct packed {
		obc_sector_t sector;
		logic        read_lock;
		logic        write_lock;
		logic        mult8;
		logic        pll_on;
		logic        rc_on;
		logic [1:0]  bo_sel;
		logic        dog_hw;
		logic        dog_halt;
	} obc_cfg_t;

endpackage : obc_pkg

// [tb/obc_nv_model.sv]
module obc_nv_model
	import obc_pkg::*;
#(
	parameter int WIPE_DLY = 6
) (
	// Clock
	input  wire logic     clk_sys_i,
	// Storage port
	input  wire logic     nv_wr_i,
	input  wire obc_nvw_t nv_w_i,
	input  wire logic     wipe_i,
	input  wire logic     reload_i,
	output logic          wipe_done_o,
	output logic [7:0]    byte0_o,
	output logic [7:0]    byte1_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	initial begin
		byte0_o = OBC_BYTE0_RST;
		byte1_o = OBC_BYTE1_RST;
		wipe_done_o = 1'b0;
		cnt = 0;
	end
	// ==========================================================
	// Storage writes and slow whole-memory wipe
	always @(posedge clk_sys_i) begin
		if (nv_wr_i && nv_w_i.sel)
			byte1_o <= nv_w_i.data;
		if (nv_wr_i && !nv_w_i.sel)
			byte0_o <= nv_w_i.data;
		// Bench reload of the delivery bytes
		if (reload_i) begin
			byte0_o <= OBC_BYTE0_RST;
			byte1_o <= OBC_BYTE1_RST;
		end
		wipe_done_o <= wipe_i && !wipe_done_o && cnt == WIPE_DLY;
		cnt <= (wipe_i && !wipe_done_o) ? cnt + 1 : 0;
	end
endmodule // obc_nv_model

// [tb/obc_config_decode_tb.sv]
module obc_config_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import obc_pkg::*;
	logic clk_sys_i = 0, rst_i = 1, prog = 0, vld = 0, halt = 0, dsw = 0;
	logic ack, rf, nwr, wipe, done, flr, flw, den, hrst, reload = 0;
	logic [7:0] rd, b0, b1, nb0, nb1;
	logic [7:0] pb0 = 8'hFC, pb1 = 8'hEF;
	obc_req_t rq = '0;
	obc_nvw_t nw;
	obc_cfg_t cfg;
	int errors = 0, n_checks = 0, cyc = 0;
	int n_wipe = 0, w0 = 0;
	logic [31:0] rs = 32'h0001_6D63;
	// Clock combos {osc, pll off, mult} valid for a supply range
	logic [2:0] clk_tab [6] = '{3'h3, 3'h0, 3'h1, 3'h7, 3'h4, 3'h5};
	obc_config_decode dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.prog_mode_i(prog), .req_valid_i(vld), .req_i(rq), .ack_o(ack),
		.refused_o(rf), .rdata_o(rd), .nv_byte0_i(nb0), .nv_byte1_i(nb1),
		.nv_wr_o(nwr), .nv_w_o(nw), .mem_wipe_o(wipe),
		.mem_wipe_done_i(done), .cfg_o(cfg), .flash_read_ok_o(flr),
		.flash_write_ok_o(flw), .dog_sw_enable_i(dsw),
		.halt_entry_i(halt), .dog_enable_o(den), .halt_reset_o(hrst));
	obc_nv_model nv_u (.clk_sys_i(clk_sys_i), .nv_wr_i(nwr), .nv_w_i(nw),
		.wipe_i(wipe), .wipe_done_o(done), .byte0_o(nb0), .byte1_o(nb1),
		.reload_i(reload));
	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (wipe === 1'b1)
			n_wipe++;
		if (cyc == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [15:0] dec(input logic [7:0] a, c);
		obc_cfg_t e;
		e.sector = a[3] ? OBC_SEC_ONEHALF : obc_sector_t'({1'b0, a[2]});
		e.read_lock = a[1];
		e.write_lock = a[0];
		e.mult8 = c[7];
		e.pll_on = !c[6];
		e.rc_on = !c[4];
		e.bo_sel = c[3:2];
		e.dog_hw = !c[1];
		e.dog_halt = c[0];
		return 16'(e);
	endfunction
	task automatic chk(input string nm, input logic [15:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic req(input obc_cmd_t c, input logic s, logic [7:0] w);
		int n;
		@(posedge clk_sys_i) #1 vld = 1;
		rq = '{c, s, w};
		@(posedge clk_sys_i) #1 vld = 0;
		for (n = 0; n < 40 && ack !== 1'b1; n++)
			@(posedge clk_sys_i) #1;
		chk("ack", 16'(ack), 16'h1);
	endtask
	task automatic do_rst();
		@(posedge clk_sys_i) #1 rst_i = 1;
		repeat (4) @(posedge clk_sys_i);
		#1 rst_i = 0;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic cfg_chk(input logic [7:0] a, c);
		chk("cfg", 16'(cfg), dec(a, c));
		chk("fl", 16'({flr, flw}), 16'({!a[1], !a[1] && !a[0]}));
	endtask
	task automatic halt_chk(input logic e);
		@(posedge clk_sys_i) #1 halt = 1;
		@(posedge clk_sys_i) #1 halt = 0;
		chk("halt_rst", 16'(hrst), 16'(e));
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		do_rst();
		cfg_chk(8'hFC, 8'hEF);
		req(OBC_CMD_WRITE, 1, 8'h00);
		chk("ref_off", 16'(rf), 16'h1);
		chk("b1_kept", 16'(nb1), 16'hEF);
		#1 prog = 1;
		repeat (5) @(posedge clk_sys_i);
		for (int i = 0; i < 8; i++) begin
			rs = rnd();
			b0 = {4'hF, i < 4 ? 2'(i) : rs[3:2], 2'h0};
			b1 = {clk_tab[i % 6][0], clk_tab[i % 6][1], 1'b1,
				clk_tab[i % 6][2], i < 4 ? 2'(i) : rs[5:4], rs[7:6]};
			req(OBC_CMD_WRITE, 0, b0);
			req(OBC_CMD_WRITE, 1, b1);
			req(OBC_CMD_READ, 1, 8'h00);
			chk("rd1", 16'(rd), 16'(b1));
			chk("ref", 16'(rf), 16'h0);
			cfg_chk(pb0, pb1);
			do_rst();
			cfg_chk(b0, b1);
			pb0 = b0;
			pb1 = b1;
			chk("dog", 16'(den), 16'(!b1[1]));
			halt_chk(b1[0] && !b1[1]);
			#1 dsw = 1;
			repeat (2) @(posedge clk_sys_i);
			chk("dog_sw", 16'(den), 16'h1);
			halt_chk(b1[0]);
			#1 dsw = 0;
			req(OBC_CMD_WRITE, 0, 8'hFC);
			req(OBC_CMD_WRITE, 1, 8'hEF);
		end
		w0 = n_wipe;
		req(OBC_CMD_ERASE, 0, 8'h00);
		chk("no_wipe", 16'(n_wipe != w0), 16'h0);
		@(posedge clk_sys_i) #1;
		chk("er1", 16'({nb0, nb1}), 16'hFFFF);
		@(posedge clk_sys_i) #1 reload = 1;
		@(posedge clk_sys_i) #1 reload = 0;
		req(OBC_CMD_WRITE, 0, 8'hF2);
		do_rst();
		cfg_chk(8'hF2, 8'hEF);
		w0 = n_wipe;
		req(OBC_CMD_ERASE, 0, 8'h00);
		chk("wipe", 16'(n_wipe != w0), 16'h1);
		@(posedge clk_sys_i) #1;
		chk("er2", 16'({nb0, nb1}), 16'hFFFF);
		@(posedge clk_sys_i) #1 reload = 1;
		@(posedge clk_sys_i) #1 reload = 0;
		req(OBC_CMD_WRITE, 0, 8'hF1);
		req(OBC_CMD_WRITE, 0, 8'hFC);
		chk("wl_wr", 16'(rf), 16'h1);
		req(OBC_CMD_ERASE, 0, 8'h00);
		chk("wl_er", 16'(rf), 16'h1);
		req(OBC_CMD_READ, 0, 8'h00);
		chk("wl_b0", 16'(rd), 16'hF1);
		do_rst();
		cfg_chk(8'hF1, 8'hEF);
		report_and_stop();
	end
endmodule // obc_config_decode_tb
